// ==== rtl/isr_bank.sv ====
`timescale 1ns/1ps
module isr_bank
    import isr_pkg::*;
#(
    parameter int unsigned TICK_CYC = SEC_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // register read port
    input wire logic i_rd_en,
    input wire logic [15:0] i_rd_addr,
    input wire logic i_rd_fieldbus,
    output logic o_rd_valid,
    output logic [15:0] o_rd_data,
    output logic o_rd_exc,
    // command port
    input wire logic i_cmd_wr,
    input wire logic [15:0] i_cmd_code,
    output logic o_cmd_ack,
    output logic o_cmd_exc,
    input wire logic i_prog_reset_clr,
    // instrument core status
    input wire logic i_power_fail,
    input wire logic i_boot_done,
    input wire logic i_boot_err,
    input wire logic i_boot_fatal,
    input wire logic [15:0] i_warm_s,
    input wire logic [7:0] i_err_code,
    input wire logic [7:0] i_scale_err,
    input wire logic [2:0] i_good_zero,
    input wire logic i_net_mode,
    input wire logic i_motion,
    input wire logic i_flow_disp,
    input wire logic signed [31:0] i_gross,
    input wire logic signed [31:0] i_net,
    input wire logic signed [31:0] i_in_signal,
    input wire logic signed [31:0] i_aout_raw,
    // state outputs
    output logic [7:0] o_op_code,
    output logic o_remote
);
    isr_op_if op ();
    // register group picked by the read address
    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_STATE,
        SEL_ERR,
        SEL_STATUS,
        SEL_SERR,
        SEL_SSTAT,
        SEL_GROSS,
        SEL_NET,
        SEL_FLOW,
        SEL_INSIG,
        SEL_AOUT
    } isr_sel_t;

    logic pf_meta_q, pf_sync_q;
    logic remote_q, remote_d;
    logic prog_rst_q, prog_rst_d;
    logic ack_q, ack_d;
    logic cexc_q, cexc_d;
    logic rvalid_q, rvalid_d;
    logic [15:0] rdata_q, rdata_d;
    logic rexc_q, rexc_d;
    logic [7:0] code_q;
    logic start_q, start_d;
    logic [15:0] ovr_stat;
    logic [15:0] scl_stat;
    logic signed [31:0] aout_rnd;
    logic signed [31:0] flow_val;
    logic [15:0] off;
    isr_sel_t sel;

    // three-register value: sign word, high half, low half
    // the master joins the three registers back into one value
    function automatic logic [15:0] word3(input logic signed [31:0] v,
                                          input logic [15:0] idx);
        logic [15:0] w;
        w = 16'h0000;
        case (idx)
            16'h0000: w = {16{v[31]}};
            16'h0001: w = v[31:16];
            16'h0002: w = v[15:0];
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    // value does not fit a signed 16-bit register
    // every bit above bit 14 must equal the sign bit
    function automatic logic big16(input logic signed [31:0] v);
        return !((&v[31:15]) || ~(|v[31:15]));
    endfunction

    // magnitude beyond six decimal digits
    // the most negative value wraps on negation yet stays above the limit
    function automatic logic over6(input logic signed [31:0] v);
        logic [31:0] mag;
        mag = v[31] ? 32'(-v) : 32'(v);
        return mag > SIX_DIGIT_MAX;
    endfunction

    // power-fail pin synchroniser
    // the pin is asynchronous, so only the second flop feeds logic
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pf_meta_q <= 1'b0;
            pf_sync_q <= 1'b0;
        end else begin
            pf_meta_q <= i_power_fail;
            pf_sync_q <= pf_meta_q;
        end
    end

    // operating-state machine hookup
    assign op.start = start_q;
    assign op.pfail = pf_sync_q;
    // core start-up results share this clock, no synchroniser
    assign op.boot_done = i_boot_done;
    assign op.boot_err = i_boot_err;
    assign op.boot_fatal = i_boot_fatal;
    assign op.warm_s = i_warm_s;

    isr_op_fsm #(
        .TICK_CYC(TICK_CYC)
    ) u_fsm (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .op(op.fsm)
    );

    assign flow_val = 32'sh00000000;

    // round ten-thousandths to thousandths
    // division truncates toward zero, hence the half step away from zero
    assign aout_rnd = i_aout_raw[31] ? (i_aout_raw - RND_HALF) / RND_DIV
                                     : (i_aout_raw + RND_HALF) / RND_DIV;

    // overall status word
    always_comb begin
        ovr_stat = 16'h0000;
        ovr_stat[ST_REMOTE] = remote_q;
        ovr_stat[ST_PROG_RESET] = prog_rst_q;
    end

    // scale status word
    always_comb begin
        scl_stat = 16'h0000;
        // flow is held at zero, so its overflow bit stays clear
        // scaled integer overflow
        scl_stat[SC_NET_BIG] = big16(i_net);
        scl_stat[SC_GROSS_BIG] = big16(i_gross);
        scl_stat[SC_FLOW_BIG] = big16(flow_val);
        scl_stat[SC_ZERO_DISP] = i_good_zero[0];
        scl_stat[SC_ZERO_GROSS] = i_good_zero[1];
        scl_stat[SC_ZERO_NET] = i_good_zero[2];
        scl_stat[SC_NET_MODE] = i_net_mode;
        scl_stat[SC_MOTION] = i_motion;
        scl_stat[SC_FLOW_DISP] = i_flow_disp;
        scl_stat[SC_NET_PREC] = over6(i_net);
        scl_stat[SC_GROSS_PREC] = over6(i_gross);
    end

    // command decode
    always_comb begin
        remote_d = remote_q;
        start_d = 1'b0;
        ack_d = i_cmd_wr;
        cexc_d = 1'b0;
        if (i_cmd_wr) begin
            case (i_cmd_code)
                CMD_START: begin
                    if (op.in_wait) start_d = 1'b1;
                    else cexc_d = 1'b1;
                end
                CMD_REMOTE_ON: remote_d = 1'b1;
                CMD_REMOTE_OFF: remote_d = 1'b0;
                // other codes acknowledged, no effect
                default: cexc_d = 1'b0;
            endcase
        end
    end

    // command registers; start is a one-cycle pulse
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            remote_q <= 1'b0;
            start_q <= 1'b0;
            ack_q <= 1'b0;
            cexc_q <= 1'b0;
        end else begin
            remote_q <= remote_d;
            start_q <= start_d;
            ack_q <= ack_d;
            cexc_q <= cexc_d;
        end
    end

    // address decode into register group and word offset
    always_comb begin
        sel = SEL_NONE;
        off = 16'h0000;
        if (i_rd_addr == REG_OP_STATE) begin
            sel = SEL_STATE;
        end else if (i_rd_addr == REG_ERR_CODE) begin
            sel = SEL_ERR;
        end else if (i_rd_addr == REG_STATUS) begin
            sel = SEL_STATUS;
        end else if (i_rd_addr == REG_SCALE_ERR) begin
            sel = SEL_SERR;
        end else if (i_rd_addr == REG_SCALE_STAT) begin
            sel = SEL_SSTAT;
        end else if (i_rd_addr >= REG_GROSS && i_rd_addr < REG_NET) begin
            sel = SEL_GROSS;
            off = i_rd_addr - REG_GROSS;
        end else if (i_rd_addr >= REG_NET && i_rd_addr < REG_FLOW) begin
            sel = SEL_NET;
            off = i_rd_addr - REG_NET;
        end else if (i_rd_addr >= REG_FLOW && i_rd_addr < REG_INSIG) begin
            sel = SEL_FLOW;
            off = i_rd_addr - REG_FLOW;
        end else if (i_rd_addr >= REG_INSIG
                     && i_rd_addr < REG_INSIG + 16'h0003) begin
            sel = SEL_INSIG;
            off = i_rd_addr - REG_INSIG;
        end else if (i_rd_addr >= REG_AOUT
                     && i_rd_addr < REG_AOUT + 16'h0003) begin
            sel = SEL_AOUT;
            off = i_rd_addr - REG_AOUT;
        end
    end

    // read data mux; the gap before the analog output stays unmapped
    always_comb begin
        rvalid_d = i_rd_en;
        rdata_d = 16'h0000;
        rexc_d = 1'b0;
        if (i_rd_en) begin
            case (sel)
                SEL_STATE: rdata_d = {8'h00, op.op_code};
                SEL_ERR: rdata_d = {8'h00, i_err_code};
                SEL_STATUS: rdata_d = ovr_stat;
                SEL_SERR: rdata_d = {8'h00, i_scale_err};
                SEL_SSTAT: rdata_d = scl_stat;
                // three-word values: sign, high, low
                SEL_GROSS: rdata_d = word3(i_gross, off);
                SEL_NET: rdata_d = word3(i_net, off);
                // flow word comes from the zero constant
                SEL_FLOW: rdata_d = word3(flow_val, off);
                SEL_INSIG: rdata_d = word3(i_in_signal, off);
                SEL_AOUT: rdata_d = word3(aout_rnd, off);
                // unmapped number answers with an exception
                default: rexc_d = 1'b1;
            endcase
        end
    end

    // program-reset flag, never set again until reset
    always_comb begin
        prog_rst_d = prog_rst_q;
        if (i_rd_en && sel == SEL_STATUS && !i_rd_fieldbus) prog_rst_d = 1'b0;
        if (i_prog_reset_clr) prog_rst_d = 1'b0;
    end

    // read answer registers
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 16'h0000;
            rexc_q <= 1'b0;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rexc_q <= rexc_d;
        end
    end

    // program-reset flag register
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prog_rst_q <= ST_PROG_RESET_RST;
        end else begin
            prog_rst_q <= prog_rst_d;
        end
    end

    // state code pipeline, one flop after the register view
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            code_q <= OPC_STARTUP;
        end else begin
            code_q <= op.op_code;
        end
    end

    // outputs, all from flops
    // the state code lags the register view by one cycle
    assign o_rd_valid = rvalid_q;
    assign o_rd_data = rdata_q;
    assign o_rd_exc = rexc_q;
    assign o_cmd_ack = ack_q;
    assign o_cmd_exc = cexc_q;
    assign o_op_code = code_q;
    assign o_remote = remote_q;
endmodule // isr_bank

// ==== rtl/isr_pkg.sv ====
package isr_pkg;
    // clock and warm-up timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned WARM_UNIT_S = 1;
    localparam int unsigned SEC_CYC = CLK_HZ * WARM_UNIT_S;
    localparam int CYC_W = 25;
    // operating-state codes as read by the master
    localparam logic [7:0] OPC_STARTUP = 8'h00;
    localparam logic [7:0] OPC_WAIT = 8'h01;
    localparam logic [7:0] OPC_WARMUP = 8'h02;
    localparam logic [7:0] OPC_NORMAL = 8'h03;
    localparam logic [7:0] OPC_ERROR = 8'h04;
    localparam logic [7:0] OPC_FATAL = 8'h05;
    localparam logic [7:0] OPC_PFAIL = 8'h06;
    // holding register numbers, integer view
    localparam logic [15:0] REG_OP_STATE = 16'h9C5F;   // 40031
    localparam logic [15:0] REG_ERR_CODE = 16'h9C60;   // 40032
    localparam logic [15:0] REG_STATUS = 16'h9C61;     // 40033
    localparam logic [15:0] REG_SCALE_ERR = 16'h9C62;  // 40034
    localparam logic [15:0] REG_SCALE_STAT = 16'h9C63; // 40035
    localparam logic [15:0] REG_GROSS = 16'h9C64;      // 40036, 3 regs
    localparam logic [15:0] REG_NET = 16'h9C67;        // 40039, 3 regs
    localparam logic [15:0] REG_FLOW = 16'h9C6A;       // 40042, 3 regs
    localparam logic [15:0] REG_INSIG = 16'h9C6D;      // 40045, 3 regs
    localparam logic [15:0] REG_AOUT = 16'h9C86;       // 40070, 3 regs
    // overall status bits
    localparam int ST_REMOTE = 0;
    localparam int ST_PROG_RESET = 1;
    localparam logic ST_PROG_RESET_RST = 1'b1;
    // scale status bits
    localparam int SC_NET_BIG = 0;
    localparam int SC_GROSS_BIG = 1;
    localparam int SC_FLOW_BIG = 2;
    localparam int SC_ZERO_DISP = 3;
    localparam int SC_ZERO_GROSS = 4;
    localparam int SC_ZERO_NET = 5;
    localparam int SC_NET_MODE = 6;
    localparam int SC_MOTION = 7;
    localparam int SC_FLOW_DISP = 11;
    localparam int SC_NET_PREC = 12;
    localparam int SC_GROSS_PREC = 13;
    // command codes
    localparam logic [15:0] CMD_START = 16'h0001;
    localparam logic [15:0] CMD_REMOTE_ON = 16'h0002;
    localparam logic [15:0] CMD_REMOTE_OFF = 16'h0003;
    // six-digit limit and rounding step
    localparam logic [31:0] SIX_DIGIT_MAX = 32'h000F423F;
    localparam logic signed [31:0] RND_HALF = 32'sh00000005;
    localparam logic signed [31:0] RND_DIV = 32'sh0000000A;
    // operating state encoding, gray along the start-up path
    typedef enum logic [2:0] {
        S_BOOT = 3'b000,
        S_WAIT = 3'b001,
        S_WARM = 3'b011,
        S_NORM = 3'b010,
        S_ERR = 3'b110,
        S_FATAL = 3'b111,
        S_PFAIL = 3'b100
    } isr_state_t;
endpackage

// ==== rtl/isr_op_if.sv ====
`timescale 1ns/1ps
interface isr_op_if;
    logic start;
    logic pfail;
    logic boot_done;
    logic boot_err;
    logic boot_fatal;
    logic [15:0] warm_s;
    logic [7:0] op_code;
    logic in_wait;
    modport fsm (
        input start, pfail, boot_done, boot_err, boot_fatal, warm_s,
        output op_code, in_wait
    );
    modport bank (
        output start, pfail, boot_done, boot_err, boot_fatal, warm_s,
        input op_code, in_wait
    );
endinterface

// ==== rtl/isr_op_fsm.sv ====
`timescale 1ns/1ps
module isr_op_fsm
    import isr_pkg::*;
#(
    parameter int unsigned TICK_CYC = SEC_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    isr_op_if.fsm op
);
    isr_state_t state_q, state_d;
    logic [CYC_W-1:0] cyc_q, cyc_d;
    logic [15:0] wsec_q, wsec_d;
    logic [7:0] code_q, code_d;
    logic tick;

    assign tick = (cyc_q == CYC_W'(TICK_CYC - 1));

    // next state, warm-up countdown and reported code
    always_comb begin
        state_d = state_q;
        cyc_d = cyc_q;
        wsec_d = wsec_q;
        case (state_q)
            S_BOOT: begin
                if (op.boot_fatal) state_d = S_FATAL;
                else if (op.boot_err) state_d = S_ERR;
                else if (op.boot_done) state_d = S_WAIT;
            end
            S_WAIT: begin
                if (op.start) begin
                    if (op.warm_s != 16'h0000) begin
                        state_d = S_WARM;
                        wsec_d = op.warm_s;
                        cyc_d = '0;
                    end else begin
                        state_d = S_NORM;
                    end
                end
            end
            S_WARM: begin
                cyc_d = tick ? '0 : cyc_q + CYC_W'(1);
                if (tick) begin
                    wsec_d = wsec_q - 16'h0001;
                    if (wsec_q == 16'h0001) state_d = S_NORM;
                end
            end
            S_NORM: state_d = S_NORM;
            S_ERR: begin
                if (op.boot_done && !op.boot_err) state_d = S_WAIT;
            end
            S_FATAL: state_d = S_FATAL;
            S_PFAIL: state_d = S_PFAIL;
            default: state_d = S_BOOT;
        endcase
        if (op.pfail && state_q != S_FATAL) state_d = S_PFAIL;
        case (state_d)
            S_BOOT: code_d = OPC_STARTUP;
            S_WAIT: code_d = OPC_WAIT;
            S_WARM: code_d = OPC_WARMUP;
            S_NORM: code_d = OPC_NORMAL;
            S_ERR: code_d = OPC_ERROR;
            S_FATAL: code_d = OPC_FATAL;
            S_PFAIL: code_d = OPC_PFAIL;
            default: code_d = OPC_STARTUP;
        endcase
    end

    // state registers
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= S_BOOT;
            cyc_q <= '0;
            wsec_q <= 16'h0000;
            code_q <= OPC_STARTUP;
        end else begin
            state_q <= state_d;
            cyc_q <= cyc_d;
            wsec_q <= wsec_d;
            code_q <= code_d;
        end
    end

    assign op.op_code = code_q;
    assign op.in_wait = (state_q == S_WAIT);
endmodule // isr_op_fsm

// ==== tb/isr_bank_chk.sv ====
`timescale 1ns/1ps
module isr_bank_chk
    import isr_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_rd_en,
    input wire logic [15:0] i_rd_addr,
    input wire logic [15:0] o_rd_data,
    input wire logic i_cmd_wr,
    input wire logic [15:0] i_cmd_code,
    input wire logic o_cmd_ack,
    input wire logic [7:0] i_err_code,
    input wire logic [7:0] i_scale_err,
    input wire logic [2:0] i_good_zero,
    input wire logic i_net_mode,
    input wire logic i_motion,
    input wire logic i_flow_disp,
    input wire logic [7:0] o_op_code,
    input wire logic o_remote
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);
    // decoded read requests and remote commands
    wire logic rd_err = i_rd_en && i_rd_addr == REG_ERR_CODE;
    wire logic rd_serr = i_rd_en && i_rd_addr == REG_SCALE_ERR;
    wire logic rd_scl = i_rd_en && i_rd_addr == REG_SCALE_STAT;
    wire logic rd_st = i_rd_en && i_rd_addr == REG_STATUS;
    wire logic rd_flow = i_rd_en && i_rd_addr - REG_FLOW < 16'h0003;
    wire logic cmd_rem = i_cmd_wr && (i_cmd_code == CMD_REMOTE_ON || i_cmd_code == CMD_REMOTE_OFF);
    property p_err; rd_err |=> o_rd_data == {8'h00, $past(i_err_code)}; endproperty
    a_err: assert property (p_err) else $error("error code mismatch");
    property p_serr; rd_serr |=> o_rd_data == {8'h00, $past(i_scale_err)}; endproperty
    a_serr: assert property (p_serr) else $error("scale error mismatch");
    property p_sbits; rd_scl |=> {o_rd_data[11], o_rd_data[7:3]} ==
        {$past(i_flow_disp), $past(i_motion), $past(i_net_mode), $past(i_good_zero)}; endproperty
    a_sbits: assert property (p_sbits) else $error("scale flags mismatch");
    property p_unused; rd_st |=> o_rd_data[15:2] == 14'h0000; endproperty
    a_unused: assert property (p_unused) else $error("spare status bits set");
    property p_flow; rd_flow |=> o_rd_data == 16'h0000; endproperty
    a_flow: assert property (p_flow) else $error("flow rate not zero");
    property p_remote; cmd_rem |=> o_cmd_ack && o_remote == !$past(i_cmd_code[0]); endproperty
    a_remote: assert property (p_remote) else $error("remote flag wrong");
    property p_fatal; o_op_code == OPC_FATAL |=> o_op_code == OPC_FATAL; endproperty
    a_fatal: assert property (p_fatal) else $error("fatal state left");
    property p_pfail; o_op_code == OPC_PFAIL |=> o_op_code == OPC_PFAIL; endproperty
    a_pfail: assert property (p_pfail) else $error("power fail state left");
    // main scenarios reached
    c_status: cover property (rd_st);
    c_remote: cover property (o_remote);
    c_normal: cover property (o_op_code == OPC_NORMAL);
endmodule // isr_bank_chk

bind isr_bank isr_bank_chk u_isr_bank_chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .i_cmd_wr(i_cmd_wr),
    .i_cmd_code(i_cmd_code), .o_cmd_ack(o_cmd_ack), .i_err_code(i_err_code),
    .i_scale_err(i_scale_err), .i_good_zero(i_good_zero), .i_net_mode(i_net_mode),
    .i_motion(i_motion), .i_flow_disp(i_flow_disp), .o_op_code(o_op_code),
    .o_remote(o_remote));

// ==== tb/isr_master_model.sv ====
`timescale 1ns/1ps
module isr_master_model (
    input wire logic i_ref_clk,
    output logic o_rd_en,
    output logic [15:0] o_rd_addr,
    output logic o_rd_fieldbus,
    output logic o_cmd_wr,
    output logic [15:0] o_cmd_code
);
    // idle lines at time zero
    initial begin
        {o_rd_en, o_rd_fieldbus, o_cmd_wr} = 3'h0;
        {o_rd_addr, o_cmd_code} = 32'h00000000;
    end
    // one read, address scrambled once released
    task automatic rd(input logic [15:0] a, input logic fb);
        @(posedge i_ref_clk);
        o_rd_en <= 1'b1;
        o_rd_addr <= a;
        o_rd_fieldbus <= fb;
        @(posedge i_ref_clk);
        o_rd_en <= 1'b0;
        o_rd_addr <= ~a;
        o_rd_fieldbus <= ~fb;
    endtask
    // one command write
    task automatic cmd(input logic [15:0] c);
        @(posedge i_ref_clk);
        o_cmd_wr <= 1'b1;
        o_cmd_code <= c;
        @(posedge i_ref_clk);
        o_cmd_wr <= 1'b0;
        o_cmd_code <= ~c;
    endtask
endmodule // isr_master_model

// ==== tb/isr_bank_tb_top.sv ====
`timescale 1ns/1ps
module isr_bank_tb_top;
    import isr_pkg::*;
    localparam int unsigned TICK = 10;
    logic i_ref_clk, i_reset_n, i_rd_en, i_rd_fieldbus, i_cmd_wr, i_prog_reset_clr, i_power_fail;
    logic i_boot_done, i_boot_err, i_boot_fatal, i_net_mode, i_motion, i_flow_disp;
    logic o_rd_valid, o_rd_exc, o_cmd_ack, o_cmd_exc, o_remote;
    logic [15:0] i_rd_addr, i_cmd_code, i_warm_s, o_rd_data, a;
    logic [7:0] i_err_code, i_scale_err, o_op_code;
    logic [2:0] i_good_zero;
    logic signed [31:0] i_gross, i_net, i_in_signal, i_aout_raw;
    logic [16:0] exp_q[$];
    logic cexp_q[$];
    int bad_count, n_compared, seed, n, j;
    // bench clock
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    isr_master_model u_isr_master_model (.i_ref_clk(i_ref_clk), .o_rd_en(i_rd_en),
        .o_rd_addr(i_rd_addr), .o_rd_fieldbus(i_rd_fieldbus), .o_cmd_wr(i_cmd_wr),
        .o_cmd_code(i_cmd_code));
    isr_bank #(.TICK_CYC(TICK)) u_isr_bank (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .i_rd_fieldbus(i_rd_fieldbus),
        .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_rd_exc(o_rd_exc),
        .i_cmd_wr(i_cmd_wr), .i_cmd_code(i_cmd_code), .o_cmd_ack(o_cmd_ack),
        .o_cmd_exc(o_cmd_exc), .i_prog_reset_clr(i_prog_reset_clr),
        .i_power_fail(i_power_fail), .i_boot_done(i_boot_done), .i_boot_err(i_boot_err),
        .i_boot_fatal(i_boot_fatal), .i_warm_s(i_warm_s), .i_err_code(i_err_code),
        .i_scale_err(i_scale_err), .i_good_zero(i_good_zero), .i_net_mode(i_net_mode),
        .i_motion(i_motion), .i_flow_disp(i_flow_disp), .i_gross(i_gross), .i_net(i_net),
        .i_in_signal(i_in_signal), .i_aout_raw(i_aout_raw), .o_op_code(o_op_code),
        .o_remote(o_remote));
    // compare and count
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // verdict and stop
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic out_of(input logic signed [31:0] v, input int hi, input int lo);
        return v > hi || v < lo;
    endfunction
    // expected answer of a data register
    function automatic logic [16:0] exp_of(input logic [15:0] ad);
        logic signed [31:0] v;
        logic [15:0] b;
        logic [15:0] bs[4] = '{REG_GROSS, REG_NET, REG_FLOW, REG_INSIG};
        logic signed [31:0] vs[4] = '{i_gross, i_net, 32'sh00000000, i_in_signal};
        b = REG_AOUT;
        v = (i_aout_raw < 0) ? (i_aout_raw - RND_HALF) / RND_DIV
                             : (i_aout_raw + RND_HALF) / RND_DIV;
        if (ad == REG_ERR_CODE) return {9'h000, i_err_code};
        if (ad == REG_STATUS) return 17'h00000;
        if (ad == REG_SCALE_ERR) return {9'h000, i_scale_err};
        if (ad == REG_SCALE_STAT) return {3'h0, out_of(i_gross, SIX_DIGIT_MAX, -SIX_DIGIT_MAX),
            out_of(i_net, SIX_DIGIT_MAX, -SIX_DIGIT_MAX), i_flow_disp, 3'h0, i_motion,
            i_net_mode, i_good_zero, 1'b0, out_of(i_gross, 32'sh00007FFF, -32'sh00008000),
            out_of(i_net, 32'sh00007FFF, -32'sh00008000)};
        foreach (bs[k]) if (ad - bs[k] < 16'h0003) begin
            b = bs[k];
            v = vs[k];
        end
        if (ad - b > 16'h0002) return 17'h10000;
        if (ad == b) return {1'b0, {16{v[31]}}};
        return {1'b0, (ad == b + 16'h0001) ? v[31:16] : v[15:0]};
    endfunction
    // requests with their expected answers noted
    task automatic rd(input logic [15:0] ad, input logic fb, input logic [16:0] e);
        exp_q.push_back(e);
        u_isr_master_model.rd(ad, fb);
    endtask
    task automatic cmd(input logic [15:0] c, input logic e);
        cexp_q.push_back(e);
        u_isr_master_model.cmd(c);
    endtask
    task automatic do_reset(input logic [2:0] boot);
        // let the last answer land before the reset wipes it
        if (i_reset_n) @(posedge i_ref_clk);
        i_reset_n <= 1'b0;
        i_power_fail <= 1'b0;
        {i_boot_fatal, i_boot_err, i_boot_done} <= boot;
        repeat (5) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
    endtask
    task automatic wait_code(input logic [7:0] c);
        for (n = 0; n < 300 && o_op_code !== c; n++) @(posedge i_ref_clk);
        if (o_op_code !== c) begin
            bad_count++;
            end_of_test;
        end
    endtask
    // answer monitor
    always @(posedge i_ref_clk) begin
        if (o_rd_valid === 1'b1)
            check({o_rd_exc, o_rd_data}, exp_q.size() ? exp_q.pop_front() : 17'h1FFFF);
        if (o_cmd_ack === 1'b1)
            check({16'h0000, o_cmd_exc}, {16'h0000, cexp_q.size() ? cexp_q.pop_front() : 1'bx});
    end
    // hang guard
    initial begin
        repeat (40000) @(posedge i_ref_clk);
        bad_count++;
        end_of_test;
    end
    // main sequence
    initial begin
        seed = 88597;
        {i_reset_n, i_prog_reset_clr, i_power_fail, i_boot_done, i_boot_err} = 5'h00;
        {i_boot_fatal, i_net_mode, i_motion, i_flow_disp, i_good_zero} = 7'h00;
        {i_warm_s, i_err_code, i_scale_err} = 32'h00000000;
        {i_gross, i_net, i_in_signal, i_aout_raw} = 128'h0;
        do_reset(3'h0);
        rd(REG_OP_STATE, 1'b0, 17'h00000);
        rd(REG_STATUS, 1'b1, 17'h00002);
        rd(REG_STATUS, 1'b1, 17'h00002);
        rd(REG_STATUS, 1'b0, 17'h00002);
        rd(REG_STATUS, 1'b0, 17'h00000);
        $display("reset flag test done");
        i_boot_done <= 1'b1;
        wait_code(OPC_WAIT);
        rd(REG_OP_STATE, 1'b0, 17'h00001);
        cmd(CMD_REMOTE_ON, 1'b0);
        rd(REG_STATUS, 1'b0, 17'h00001);
        cmd(CMD_REMOTE_OFF, 1'b0);
        cmd(16'h0007, 1'b0);
        rd(REG_STATUS, 1'b0, 17'h00000);
        i_warm_s <= 16'h0002;
        cmd(CMD_START, 1'b0);
        wait_code(OPC_WARMUP);
        for (n = 0; n < 100 && o_op_code === OPC_WARMUP; n++) @(posedge i_ref_clk);
        check(17'(n), 17'(2 * TICK));
        rd(REG_OP_STATE, 1'b0, 17'h00003);
        cmd(CMD_START, 1'b1);
        $display("state and command test done");
        // random data, each weight read beside its error code
        repeat (24) begin
            i_gross <= $random(seed) >>> ($unsigned($random(seed)) % 26);
            i_net <= $random(seed) >>> ($unsigned($random(seed)) % 26);
            i_in_signal <= $random(seed);
            i_aout_raw <= $random(seed) % 200000;
            {i_err_code, i_scale_err, i_good_zero, i_net_mode, i_motion, i_flow_disp} <=
                22'($random(seed));
            @(posedge i_ref_clk);
            for (j = 0; j < 21; j++) begin
                a = (j < 17) ? REG_ERR_CODE + 16'(j) : REG_AOUT + 16'(j - 17);
                rd(a, 1'b0, exp_of(a));
            end
        end
        rd(REG_OP_STATE, 1'b0, 17'h00003);
        $display("data register test done");
        i_power_fail <= 1'b1;
        wait_code(OPC_PFAIL);
        rd(REG_OP_STATE, 1'b0, 17'h00006);
        do_reset(3'h1);
        rd(REG_STATUS, 1'b1, 17'h00002);
        @(posedge i_ref_clk) i_prog_reset_clr <= 1'b1;
        @(posedge i_ref_clk) i_prog_reset_clr <= 1'b0;
        rd(REG_STATUS, 1'b1, 17'h00000);
        do_reset(3'h2);
        wait_code(OPC_ERROR);
        rd(REG_OP_STATE, 1'b0, 17'h00004);
        do_reset(3'h4);
        wait_code(OPC_FATAL);
        i_power_fail <= 1'b1;
        repeat (8) @(posedge i_ref_clk);
        rd(REG_OP_STATE, 1'b0, 17'h00005);
        $display("fault state test done");
        for (n = 0; n < 20 && exp_q.size() + cexp_q.size() > 0; n++) @(posedge i_ref_clk);
        if (exp_q.size() + cexp_q.size() > 0) bad_count++;
        end_of_test;
    end
endmodule // isr_bank_tb_top
